// File: rtl/osf_top.sv
// osf_top: fault-status and output control of an eight channel low-side switch
// assumes serial pins already synchronous to ref_clk; sclk sampled as a level
// Functional notes
// - fault-free status bit echoes previous command bit
// - only a mismatch signals a fault
// - command high turns output off
// - open load while off returns low
// - over current while on returns high
// - over current reported whatever the select level
// - high select: limited output stays on
// - over temperature disables only that output
// - over voltage turns all outputs off
// - new command word restores outputs after overvoltage
// - grounded select: blanking delay before shutdown
// - grounded select: shutdown holds until next write
// - logic undervoltage: outputs off, command reset to all off
`timescale 1ns/100ps
module osf_top
  import osf_pkg::*;
#(
  parameter int BLANK_CYC = OSF_BLANK_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire osf_link_t         link,
  input  wire logic              short_fault_shutdown_select,
  input  wire osf_fault_t        fault,
  input  wire osf_supply_t       supply,
  output logic                   so,
  output logic                   so_oe_n,
  output logic [OSF_CH-1:0]      out_on
);

  typedef enum logic [1:0] {OSF_IDLE, OSF_SHIFT} osf_state_t;

  osf_state_t       state_r;
  osf_state_t       state_nxt;
  logic [7:0]       shift_r;
  logic [7:0]       shift_nxt;
  logic [7:0]       cmd_r;
  logic [7:0]       cmd_nxt;
  logic             sclk_r;
  logic             sclk_nxt;
  logic             ov_lat_r;
  logic             ov_lat_nxt;
  logic             so_r;
  logic             so_nxt;
  logic             new_word;
  logic             word_done_r;
  logic             word_done_nxt;
  logic [7:0]       status;
  logic [OSF_CH-1:0] gate;
  logic             kill;

  ////////////////////////////////////////////////////////////////////////
  // status word built from the state standing before the transfer opens
  genvar g;
  generate
    for (g = 0; g < OSF_CH; g++) begin : g_ch
      // off: echo high unless an open load pulls it low
      // on: echo low unless over current or heat report high
      assign status[g] = cmd_r[g] ? !fault.open_load[g]
                                  : (fault.over_cur[g] || fault.over_temp[g]);

      osf_chan #(
        .BLANK_CYC (BLANK_CYC)
      ) u_chan (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .cmd_off   (cmd_r[g]),
        .new_word  (word_done_r),  // one cycle late, so cmd_off already holds the new word
        .sfd_sel   (short_fault_shutdown_select),
        .over_cur  (fault.over_cur[g]),
        .over_temp (fault.over_temp[g]),
        .kill      (kill),
        .gate_on   (gate[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // shift engine: load on cs fall, shift si in on sclk rise, drive so on fall
  always_comb begin
    state_nxt  = state_r;
    shift_nxt  = shift_r;
    cmd_nxt    = cmd_r;
    sclk_nxt   = link.sclk;
    so_nxt     = so_r;
    new_word   = 1'b0;
    case (state_r)
      OSF_IDLE: begin
        if (!link.cs_n) begin
          shift_nxt = status;
          so_nxt    = status[OSF_MSB_POS];
          state_nxt = OSF_SHIFT;
        end
      end
      OSF_SHIFT: begin
        if (link.cs_n) begin
          // word takes effect on cs rise
          cmd_nxt   = shift_r;
          new_word  = 1'b1;
          state_nxt = OSF_IDLE;
        end else if (link.sclk && !sclk_r) begin
          shift_nxt = {shift_r[6:0], link.si};
        end else if (!link.sclk && sclk_r) begin
          so_nxt = shift_r[OSF_MSB_POS];
        end
      end
      default: begin
        state_nxt = OSF_IDLE;
      end
    endcase
    // logic undervoltage forces the off pattern into the command
    if (supply.logic_uv) begin
      cmd_nxt   = OSF_CMD_RST;
      new_word  = 1'b0;
    end
    // channels restart blanking only once cmd_r carries the new word
    word_done_nxt = new_word;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= OSF_IDLE;
      shift_r <= OSF_CMD_RST;
      cmd_r   <= OSF_CMD_RST;
      sclk_r  <= 1'b0;
      so_r    <= 1'b0;
      word_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cmd_r   <= cmd_nxt;
      sclk_r  <= sclk_nxt;
      so_r    <= so_nxt;
      word_done_r <= word_done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // over voltage latch: set wins over the clearing word
  always_comb begin
    ov_lat_nxt = ov_lat_r;
    if (new_word) begin
      ov_lat_nxt = 1'b0;
    end
    if (supply.over_volt) begin
      ov_lat_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ov_lat_r <= 1'b0;
    end else begin
      ov_lat_r <= ov_lat_nxt;
    end
  end

  // condition itself turns outputs off at once, latch holds them off
  assign kill    = supply.over_volt || ov_lat_r || supply.logic_uv;
  assign out_on  = gate;
  assign so      = so_r;
  assign so_oe_n = link.cs_n;  // driven only while selected

endmodule : osf_top

// File: rtl/osf_pkg.sv
// osf_pkg: shared constants and carrier types for the output switch fault logic
// assumes a 50 MHz ref_clk and eight low-side channels
package osf_pkg;

  localparam int          OSF_CH         = 8;
  localparam int          OSF_CLK_MHZ    = 50;
  // blanking delay before over-current shutdown, microseconds
  localparam int          OSF_BLANK_MIN_US = 70;
  localparam int          OSF_BLANK_MAX_US = 250;
  localparam int          OSF_BLANK_CYC  = OSF_BLANK_MIN_US * OSF_CLK_MHZ;
  localparam int          OSF_BLANK_W    = 14;
  // command word after reset: every output off (high means off)
  localparam logic [7:0]  OSF_CMD_RST    = 8'hff;
  // position of the first bit shifted on the link
  localparam int          OSF_MSB_POS    = 7;

  // analog fault detectors, one bit per channel
  typedef struct packed {
    logic [OSF_CH-1:0] open_load;
    logic [OSF_CH-1:0] over_cur;
    logic [OSF_CH-1:0] over_temp;
  } osf_fault_t;

  // global supply conditions
  typedef struct packed {
    logic over_volt;
    logic logic_uv;
  } osf_supply_t;

  // serial link pins, as seen by the device
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } osf_link_t;

endpackage : osf_pkg

// File: rtl/osf_chan.sv
// osf_chan: one output channel, gate control and over-current latch
// assumes fault inputs already synchronous to ref_clk
`timescale 1ns/100ps
module osf_chan
  import osf_pkg::*;
#(
  parameter int BLANK_CYC = OSF_BLANK_CYC
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic cmd_off,
  input  wire logic new_word,
  input  wire logic sfd_sel,
  input  wire logic over_cur,
  input  wire logic over_temp,
  input  wire logic kill,
  output logic      gate_on
);

  logic [OSF_BLANK_W-1:0] blank_r;
  logic [OSF_BLANK_W-1:0] blank_nxt;
  logic                   oc_lat_r;
  logic                   oc_lat_nxt;

  ////////////////////////////////////////////////////////////////////////
  // blanking timer restarts on every word that turns the output on
  always_comb begin
    blank_nxt  = blank_r;
    oc_lat_nxt = oc_lat_r;
    if (new_word) begin
      oc_lat_nxt = 1'b0;
      blank_nxt  = cmd_off ? '0 : OSF_BLANK_W'(BLANK_CYC);
    end else if (blank_r != '0) begin
      blank_nxt = blank_r - 1'b1;
    end
    // grounded select: latch off once blanking has expired
    if (!sfd_sel && over_cur && !cmd_off && blank_r == '0 && !new_word) begin
      oc_lat_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      blank_r  <= '0;
      oc_lat_r <= 1'b0;
    end else begin
      blank_r  <= blank_nxt;
      oc_lat_r <= oc_lat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // high select keeps current limiting on; only heat or a global kill stop it
  assign gate_on = !cmd_off && !over_temp && !kill && !oc_lat_r;

endmodule : osf_chan

// File: test/osf_chk.sv
// osf_chk: port-level checks of the output switch fault logic
// assumes binding into osf_top, everything sampled on ref_clk
`timescale 1ns/100ps
module osf_chk
  import osf_pkg::*;
#(
  parameter int BLANK_CYC = OSF_BLANK_CYC
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire osf_link_t   link,
  input wire logic        short_fault_shutdown_select,
  input wire osf_fault_t  fault,
  input wire osf_supply_t supply,
  input wire logic        so,
  input wire logic        so_oe_n,
  input wire logic [7:0]  out_on
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // supply faults force and hold outputs off
  a_ov_off: assert property (supply.over_volt |=> out_on == 8'h00)
    else $error("output on in over voltage");
  a_ov_latch: assert property (link.cs_n [*3] ##0 $past(supply.over_volt) |-> !out_on)
    else $error("output on before new word");
  a_uv_off: assert property (supply.logic_uv |=> out_on == 8'h00)
    else $error("output on in undervoltage");
  a_uv_hold: assert property (link.cs_n [*3] ##0 $past(supply.logic_uv) |-> !out_on)
    else $error("output on after undervoltage");
  a_temp_off: assert property ((fault.over_temp & $past(fault.over_temp) & out_on) == 8'h00)
    else $error("hot output on");
  // idle with steady inputs: limit mode never moves an output
  a_cur_limit: assert property (link.cs_n [*4] ##0 (short_fault_shutdown_select
    && $stable(short_fault_shutdown_select) && $stable(fault.over_temp) && $stable(supply))
    |-> $stable(out_on)) else $error("limited output moved");
  // shutdown mode: a cleared short does not restart an output
  a_shut_hold: assert property (link.cs_n [*4] ##0 (!short_fault_shutdown_select
    && $stable(short_fault_shutdown_select) && $stable(fault.over_temp) && $stable(supply))
    |-> (out_on & ~$past(out_on)) == 8'h00) else $error("output restarted");
  a_oe_cs: assert property (so_oe_n == link.cs_n)
    else $error("so enable off chip select");
  c_ov: cover property (supply.over_volt);
  c_xfer: cover property ($fell(link.cs_n));
  c_short: cover property (!short_fault_shutdown_select && |(fault.over_cur & out_on));
endmodule : osf_chk
bind osf_top osf_chk #(.BLANK_CYC(BLANK_CYC)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .link(link), .short_fault_shutdown_select(short_fault_shutdown_select), .fault(fault),
  .supply(supply), .so(so), .so_oe_n(so_oe_n), .out_on(out_on));

// File: test/osf_mst.sv
// osf_mst: serial master model, one 8-bit word per call of xfer
// assumes calls at a falling ref_clk edge; two ref_clk per sclk phase
`timescale 1ns/100ps
module osf_mst
  import osf_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  so,
  output osf_link_t  link,
  output logic [7:0] rx,
  output logic       rx_v
);
  initial begin
    link = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
    rx = 8'h00;
    rx_v = 1'b0;
  end
  ////////////////////////////////////////
  // msb first; so read just before each rise, when it has settled
  task automatic xfer(input logic [7:0] cmd);
    link.cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link.si = cmd[i];
      repeat (2) @(negedge ref_clk);
      rx[i] = so;
      link.sclk = 1'b1;
      repeat (2) @(negedge ref_clk);
      link.sclk = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    link.cs_n = 1'b1;
    link.si = ~link.si; // released line never keeps its value
    rx_v = 1'b1;
    @(negedge ref_clk);
    rx_v = 1'b0;
    @(negedge ref_clk);
  endtask : xfer
endmodule : osf_mst

// File: test/tb_output_switch_fault_reporting.sv
// tb: random words and faults, then short, over voltage and undervoltage cases
// assumes osf_mst as serial master; status words checked from a queue
`timescale 1ns/100ps
module tb_output_switch_fault_reporting;
  import osf_pkg::*;
  logic        ref_clk = 1'b0, reset_n = 1'b0, sel = 1'b1, so, so_oe_n, rx_v;
  osf_fault_t  fault = '0;
  osf_supply_t supply = '0;
  osf_link_t   link;
  logic [7:0]  out_on, rx, c, m, prev = OSF_CMD_RST;
  logic [7:0]  q[$];
  int          mismatches = 0, checks_done = 0;
  osf_top #(.BLANK_CYC(20)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
    .short_fault_shutdown_select(sel), .fault(fault), .supply(supply), .so(so),
    .so_oe_n(so_oe_n), .out_on(out_on));
  osf_mst MST (.ref_clk(ref_clk), .so(so), .link(link), .rx(rx), .rx_v(rx_v));
  initial forever #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask : chk
  // note the status owed for the previous word, then send the new one
  task automatic send(input logic [7:0] w);
    q.push_back((prev & ~fault.open_load) | (~prev & (fault.over_cur | fault.over_temp)));
    MST.xfer(w);
    prev = w;
  endtask : send
  task automatic summarize;
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  always @(posedge ref_clk) begin
    if (rx_v) chk(rx, q.pop_front(), "status word");
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
  initial begin
    void'($urandom(32'hedead114));
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    // faults and select move only between transfers
    for (int n = 0; n < 40; n++) begin
      fault = {8'($urandom), 8'($urandom), 8'($urandom & $urandom & $urandom)};
      sel = 1'($urandom);
      c = 8'($urandom);
      send(c);
      m = sel ? 8'hff : ~fault.over_cur;
      chk(out_on & m, ~c & ~fault.over_temp & m, "outputs");
    end
    // short on channel 0 in limit mode: output stays on while idle
    fault = '{open_load: 8'h00, over_cur: 8'h01, over_temp: 8'h00};
    sel = 1'b1;
    send(8'h00);
    repeat (25) @(negedge ref_clk);
    chk(out_on, 8'hff, "current limit");
    // short on channel 0 in shutdown mode
    fault = '{open_load: 8'h00, over_cur: 8'h01, over_temp: 8'h00};
    sel = 1'b0;
    send(8'h00);
    chk(out_on, 8'hff, "blanking");
    repeat (25) @(negedge ref_clk);
    chk(out_on, 8'hfe, "shutdown");
    fault.over_cur = 8'h00;
    repeat (4) @(negedge ref_clk);
    chk(out_on, 8'hfe, "latched off");
    send(8'h00);
    chk(out_on, 8'hff, "restart");
    supply.over_volt = 1'b1;
    repeat (2) @(negedge ref_clk);
    supply.over_volt = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(out_on, 8'h00, "over voltage latch");
    send(8'h00);
    chk(out_on, 8'hff, "after new word");
    supply.logic_uv = 1'b1;
    repeat (2) @(negedge ref_clk);
    supply.logic_uv = 1'b0;
    prev = OSF_CMD_RST;
    @(negedge ref_clk);
    chk(out_on, 8'h00, "undervoltage");
    send(8'h5a);
    send(8'h00);
    summarize();
  end
endmodule : tb_output_switch_fault_reporting
